/* File: uart_ctl_map.svh */
// Register map, field positions, codes and counts of the UART control slice.
// Assumes inclusion by bare name; holds definitions only.
`ifndef UART_CTL_MAP_SVH
`define UART_CTL_MAP_SVH
// Byte offsets on the register bus, one aligned word each.
`define OFS_INT_SOURCE 8'h00
`define OFS_FIFO_CONTROL 8'h04
`define OFS_LINE_FORMAT 8'h08
`define OFS_INT_MASK 8'h0C
`define OFS_FEATURE_CONTROL 8'h10
`define OFS_EXT_FEATURE 8'h14
`define OFS_PROG_TRIGGER 8'h18
// Interrupt source codes, bits 5 to 0.
`define SRC_LINE 6'h06
`define SRC_TIMEOUT 6'h0C
`define SRC_RX_READY 6'h04
`define SRC_TX_READY 6'h02
`define SRC_MODEM 6'h00
`define SRC_PAUSE 6'h10
`define SRC_FLOW 6'h20
`define SRC_NONE 6'h01
// Field positions.
`define FCR_EN 0
`define FCR_RX_RST 1
`define FCR_TX_RST 2
`define FCR_DMA 3
`define FCR_TX_TRIG 5:4
`define FCR_RX_TRIG 7:6
`define IER_RX 0
`define IER_TX 1
`define IER_LINE 2
`define IER_MODEM 3
`define IER_PAUSE 5
`define IER_RTS 6
`define IER_CTS 7
`define EFR_ENH 4
`define FEATURE_CONTROL_REG_TABLE 5:4
`define FEATURE_CONTROL_REG_TRG_SEL 7
`define LCR_LEN 1:0
`define LCR_STOP 2
`define LCR_PAR 3
`define LCR_EVEN 4
// Reset values.
`define REG_RESET 8'h00
`define LEVEL_ONE 7'h01
`define LEVEL_ZERO 7'h00
// Trigger tables, packed {code 11, code 10, code 01, code 00}.
`define TBL_A_RX {7'h0E, 7'h08, 7'h04, 7'h01}
`define TBL_B_RX {7'h1C, 7'h18, 7'h10, 7'h08}
`define TBL_B_TX {7'h1E, 7'h18, 7'h08, 7'h10}
`define TBL_C_RX {7'h3C, 7'h38, 7'h10, 7'h08}
`define TBL_C_TX {7'h38, 7'h20, 7'h10, 7'h08}
// Character timing in half bit times.
`define START_HALFS 8'h02
`define WORD_MIN_HALFS 8'h0A
`define PARITY_HALFS 8'h02
`define STOP1_HALFS 8'h02
`define STOP15_HALFS 8'h03
`define STOP2_HALFS 8'h04
`define TIMEOUT_CHARS 8'h04
`define TIMEOUT_EXTRA_HALFS 8'h18
`define COUNT_ONE 8'h01
`define COUNT_ZERO 8'h00
`endif

/* File: uart_ctl_pkg.sv */
// Types shared by the UART control slice.
// Assumes nothing of its surroundings.
package uart_ctl_pkg;
  typedef logic [6:0] level_type;
  typedef enum logic [1:0] {
    TABLE_A = 2'b00,
    TABLE_B = 2'b01,
    TABLE_C = 2'b10,
    TABLE_D = 2'b11
  } table_type;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ = 2'b10,
    BUS_DONE = 2'b11
  } bus_state_type;
endpackage

/* File: irq_prioritizer.sv */
// Picks the highest-priority pending interrupt and gives its source code.
// Assumes the requests are already gated by their masks.
`include "uart_ctl_map.svh"
module irq_prioritizer (
  input wire logic [7:1] i_active,
  output logic [5:0] o_code,
  output logic o_pending
);
  always_comb begin
    if (i_active[1]) begin
      o_code = `SRC_LINE;
    end else if (i_active[2]) begin
      o_code = `SRC_TIMEOUT;
    end else if (i_active[3]) begin
      o_code = `SRC_RX_READY;
    end else if (i_active[4]) begin
      o_code = `SRC_TX_READY;
    end else if (i_active[5]) begin
      o_code = `SRC_MODEM;
    end else if (i_active[6]) begin
      o_code = `SRC_PAUSE;
    end else if (i_active[7]) begin
      o_code = `SRC_FLOW;
    end else begin
      o_code = `SRC_NONE;
    end
  end
  assign o_pending = |i_active;
endmodule

/* File: trigger_table.sv */
// Maps trigger codes and the shared table selection to FIFO levels.
// Assumes programmable levels are held by the caller.
`include "uart_ctl_map.svh"
module trigger_table import uart_ctl_pkg::*; (
  input wire logic [1:0] i_table,
  input wire logic [1:0] i_rx_code,
  input wire logic [1:0] i_tx_code,
  input wire level_type i_prog_rx,
  input wire level_type i_prog_tx,
  output level_type o_rx_level,
  output level_type o_tx_level
);
  function automatic level_type pick(input logic [27:0] tbl,
                                     input logic [1:0] code);
    return tbl[{code, 3'b000} - {3'b000, code} +: 7];
  endfunction

  always_comb begin
    unique case (table_type'(i_table))
      TABLE_A: begin
        o_rx_level = pick(`TBL_A_RX, i_rx_code);
        o_tx_level = `LEVEL_ONE;
      end
      TABLE_B: begin
        o_rx_level = pick(`TBL_B_RX, i_rx_code);
        o_tx_level = pick(`TBL_B_TX, i_tx_code);
      end
      TABLE_C: begin
        o_rx_level = pick(`TBL_C_RX, i_rx_code);
        o_tx_level = pick(`TBL_C_TX, i_tx_code);
      end
      TABLE_D: begin
        o_rx_level = i_prog_rx;
        o_tx_level = i_prog_tx;
      end
    endcase
  end
endmodule

/* File: uart_line_ctl.sv */
// UART control slice: interrupt source encoding, FIFO control, trigger
// selection and character format, as an AHB-Lite slave.
// Assumes the datapath reports FIFO levels and line events synchronously.
`include "uart_ctl_map.svh"
// Summary of operation
// - Line status is priority 1, code 000110.
// - Timeout priority 2, data ready priority 3.
// - Transmit ready 4, modem status 5.
// - Pause or special match is priority 6.
// - Flow line change is lowest, priority 7.
// - Bit 0 low while pending; idle 000001.
// - Bits 3:1 encode highest pending source.
// - Bit 4 needs extended enable and mask 5.
// - Bit 5 needs extended enable, mask 6/7.
// - Bits 7:6 mirror FIFO enable.
// - FIFO control bits ignored unless bit 0 set.
// - FIFO reset bits pulse clears, self-clear.
// - Bit 3 picks normal or DMA requests.
// - Transmit trigger writable only when extended.
// - Receive trigger field; both default to one.
// - One trigger table serves both directions.
// - Table A: receive 1/4/8/14, transmit 1.
// - Table B levels for both directions.
// - Table C levels for both directions.
// - Table D uses programmable trigger register.
// - Format bits 1:0 set 5 to 8 bits.
// - Bit 2 selects one, 1.5 or 2 stops.
// - Bit 3 enables parity generation and checking.
// - Bit 4 selects odd or even parity.
// - Timeout after four characters plus 12 bits.
// - Transmit and line interrupts clear as documented.
module uart_line_ctl import uart_ctl_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic i_half_bit_tick,
  input wire logic i_rx_char,
  input wire logic [6:0] i_rx_level,
  input wire logic [6:0] i_tx_level,
  input wire logic i_line_error,
  input wire logic i_modem_change,
  input wire logic i_pause_match,
  input wire logic i_pause_release,
  input wire logic i_cts_deassert,
  input wire logic i_rts_deassert,
  input wire logic i_rhr_read,
  input wire logic i_thr_write,
  input wire logic i_lsr_read,
  input wire logic i_msr_read,
  output logic o_fifo_enable,
  output logic o_rx_fifo_clear,
  output logic o_tx_fifo_clear,
  output logic o_dma_mode,
  output logic [6:0] o_rx_trigger,
  output logic [6:0] o_tx_trigger,
  output logic [1:0] o_word_length,
  output logic o_stop_long,
  output logic o_parity_enable,
  output logic o_parity_even,
  output logic o_rx_request_pin_n,
  output logic o_tx_request_pin_n,
  output logic o_irq_pending
);
  logic rst_meta;
  logic rst_n;
  bus_state_type bus_state;
  logic [7:0] addr_q;
  logic addr_take;
  logic [7:0] wr_data;
  logic rd_now;
  logic [1:0] rx_code;
  logic [1:0] tx_code;
  logic [7:0] line_format_reg;
  logic [7:0] interrupt_mask_reg;
  logic [7:0] feature_control_reg;
  logic [7:0] extended_feature_reg;
  level_type prog_rx;
  level_type prog_tx;
  level_type rx_trig;
  level_type tx_trig;
  level_type tx_trig_eff;
  level_type tx_prev_level;
  logic tx_reached;
  logic line_flag;
  logic timeout_flag;
  logic tx_flag;
  logic pause_flag;
  logic flow_flag;
  logic rx_ready;
  logic tx_event;
  logic timeout_hit;
  logic timer_run;
  logic [7:0] timer_count;
  logic [7:1] active;
  logic [5:0] source_code;
  logic [7:0] interrupt_source_reg;
  logic [7:0] read_byte;

  function automatic logic wr_sel(input bus_state_type st,
                                  input logic [7:0] addr,
                                  input logic [7:0] ofs);
    return (st == BUS_WRITE) && (addr == ofs);
  endfunction

  function automatic logic [7:0] timeout_halfs(input logic [7:0] line_format);
    logic [7:0] chr;
    chr = `START_HALFS + `WORD_MIN_HALFS + {5'b00000, line_format[`LCR_LEN], 1'b0};
    if (line_format[`LCR_PAR]) begin
      chr = chr + `PARITY_HALFS;
    end
    if (!line_format[`LCR_STOP]) begin
      chr = chr + `STOP1_HALFS;
    end else if (line_format[`LCR_LEN] == 2'b00) begin
      chr = chr + `STOP15_HALFS;
    end else begin
      chr = chr + `STOP2_HALFS;
    end
    return 8'(chr * `TIMEOUT_CHARS) + `TIMEOUT_EXTRA_HALFS;
  endfunction

  // Reset is released through two flops; assertion stays asynchronous.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Reads take one wait state so read data comes from a flop and always
  // sees a write completed just before it.
  assign addr_take = i_hsel && i_htrans[1] && i_hready;
  assign o_hreadyout = (bus_state != BUS_READ);
  assign o_hresp = 1'b0;
  assign wr_data = i_hwdata[7:0];
  assign rd_now = (bus_state == BUS_READ);

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= BUS_IDLE;
      addr_q <= `REG_RESET;
    end else begin
      unique case (bus_state)
        BUS_READ: bus_state <= BUS_DONE;
        BUS_IDLE, BUS_WRITE, BUS_DONE: begin
          if (addr_take) begin
            bus_state <= i_hwrite ? BUS_WRITE : BUS_READ;
            addr_q <= i_haddr[7:0];
          end else begin
            bus_state <= BUS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_fifo_enable <= 1'b0;
      o_dma_mode <= 1'b0;
      rx_code <= 2'b00;
      tx_code <= 2'b00;
    end else if (wr_sel(bus_state, addr_q, `OFS_FIFO_CONTROL)) begin
      o_fifo_enable <= wr_data[`FCR_EN];
      if (wr_data[`FCR_EN]) begin
        o_dma_mode <= wr_data[`FCR_DMA];
        rx_code <= wr_data[`FCR_RX_TRIG];
        if (extended_feature_reg[`EFR_ENH]) begin
          tx_code <= wr_data[`FCR_TX_TRIG];
        end
      end
    end
  end

  // The reset bits are never stored, so they read back as cleared.
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_rx_fifo_clear <= 1'b0;
      o_tx_fifo_clear <= 1'b0;
    end else begin
      o_rx_fifo_clear <= wr_sel(bus_state, addr_q, `OFS_FIFO_CONTROL)
        && wr_data[`FCR_EN] && wr_data[`FCR_RX_RST];
      o_tx_fifo_clear <= wr_sel(bus_state, addr_q, `OFS_FIFO_CONTROL)
        && wr_data[`FCR_EN] && wr_data[`FCR_TX_RST];
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      line_format_reg <= `REG_RESET;
      interrupt_mask_reg <= `REG_RESET;
      feature_control_reg <= `REG_RESET;
      extended_feature_reg <= `REG_RESET;
    end else begin
      if (wr_sel(bus_state, addr_q, `OFS_LINE_FORMAT)) begin
        line_format_reg <= wr_data;
      end
      if (wr_sel(bus_state, addr_q, `OFS_INT_MASK)) begin
        interrupt_mask_reg <= wr_data;
      end
      if (wr_sel(bus_state, addr_q, `OFS_FEATURE_CONTROL)) begin
        feature_control_reg <= wr_data;
      end
      if (wr_sel(bus_state, addr_q, `OFS_EXT_FEATURE)) begin
        extended_feature_reg <= wr_data;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prog_rx <= `LEVEL_ONE;
      prog_tx <= `LEVEL_ONE;
    end else if (wr_sel(bus_state, addr_q, `OFS_PROG_TRIGGER)) begin
      if (feature_control_reg[`FEATURE_CONTROL_REG_TRG_SEL]) begin
        prog_tx <= wr_data[6:0];
      end else begin
        prog_rx <= wr_data[6:0];
      end
    end
  end

  assign o_word_length = line_format_reg[`LCR_LEN];
  assign o_stop_long = line_format_reg[`LCR_STOP];
  assign o_parity_enable = line_format_reg[`LCR_PAR];
  assign o_parity_even = line_format_reg[`LCR_EVEN];

  // A single table field means the last selection governs both sides.
  trigger_table u_trigger_table (
    .i_table(feature_control_reg[`FEATURE_CONTROL_REG_TABLE]),
    .i_rx_code(rx_code),
    .i_tx_code(tx_code),
    .i_prog_rx(prog_rx),
    .i_prog_tx(prog_tx),
    .o_rx_level(rx_trig),
    .o_tx_level(tx_trig)
  );

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_rx_trigger <= `LEVEL_ONE;
      o_tx_trigger <= `LEVEL_ONE;
    end else begin
      o_rx_trigger <= rx_trig;
      o_tx_trigger <= tx_trig;
    end
  end

  // Without FIFOs the holding register acts as a one-deep FIFO.
  assign tx_trig_eff = o_fifo_enable ? tx_trig : `LEVEL_ONE;
  assign rx_ready = o_fifo_enable ? (i_rx_level >= rx_trig)
                                  : (i_rx_level != `LEVEL_ZERO);
  assign o_rx_request_pin_n = !(o_dma_mode ? rx_ready
                                           : (i_rx_level != `LEVEL_ZERO));
  assign o_tx_request_pin_n = !(o_dma_mode ? (i_tx_level < tx_trig_eff)
                                           : (i_tx_level == `LEVEL_ZERO));

  // Transmit ready fires on falling below a reached trigger, on emptying,
  // or when the mask is opened while already empty.
  assign tx_event = (tx_reached && (i_tx_level < tx_trig_eff))
    || ((i_tx_level == `LEVEL_ZERO) && (tx_prev_level != `LEVEL_ZERO))
    || (wr_sel(bus_state, addr_q, `OFS_INT_MASK) && wr_data[`IER_TX]
        && !interrupt_mask_reg[`IER_TX] && (i_tx_level == `LEVEL_ZERO));

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_reached <= 1'b0;
      tx_prev_level <= `LEVEL_ZERO;
    end else begin
      tx_prev_level <= i_tx_level;
      if (i_tx_level >= tx_trig_eff) begin
        tx_reached <= 1'b1;
      end else if (tx_event) begin
        tx_reached <= 1'b0;
      end
    end
  end

  // The timer restarts on every received character and every receive holding register read.
  assign timer_run = o_fifo_enable && (i_rx_level != `LEVEL_ZERO)
                     && !timeout_flag;
  assign timeout_hit = timer_run && i_half_bit_tick && (timer_count
    == timeout_halfs(line_format_reg) - `COUNT_ONE);

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_count <= `COUNT_ZERO;
    end else if (i_rx_char || i_rhr_read || !timer_run || timeout_hit) begin
      timer_count <= `COUNT_ZERO;
    end else if (i_half_bit_tick) begin
      timer_count <= timer_count + `COUNT_ONE;
    end
  end

  // Every sticky flag lets a new event win over a clear in the same cycle.
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      line_flag <= 1'b0;
      timeout_flag <= 1'b0;
      tx_flag <= 1'b0;
      pause_flag <= 1'b0;
      flow_flag <= 1'b0;
    end else begin
      line_flag <= i_line_error || (line_flag && !i_lsr_read);
      timeout_flag <= timeout_hit
        || (timeout_flag && !i_rhr_read);
      tx_flag <= tx_event || (tx_flag && !i_thr_write && !(rd_now
        && addr_q == `OFS_INT_SOURCE
        && source_code == `SRC_TX_READY));
      pause_flag <= i_pause_match || (pause_flag && !i_pause_release
        && !(rd_now && addr_q == `OFS_INT_SOURCE
             && source_code == `SRC_PAUSE));
      flow_flag <= i_cts_deassert || i_rts_deassert
        || (flow_flag && !i_msr_read);
    end
  end

  assign active[1] = line_flag && interrupt_mask_reg[`IER_LINE];
  assign active[2] = timeout_flag && interrupt_mask_reg[`IER_RX];
  assign active[3] = rx_ready && interrupt_mask_reg[`IER_RX];
  assign active[4] = tx_flag && interrupt_mask_reg[`IER_TX];
  assign active[5] = i_modem_change && interrupt_mask_reg[`IER_MODEM];
  assign active[6] = pause_flag && interrupt_mask_reg[`IER_PAUSE]
                     && extended_feature_reg[`EFR_ENH];
  assign active[7] = flow_flag && extended_feature_reg[`EFR_ENH]
    && (interrupt_mask_reg[`IER_RTS]
        || interrupt_mask_reg[`IER_CTS]);

  irq_prioritizer u_irq_prioritizer (
    .i_active(active),
    .o_code(source_code),
    .o_pending(o_irq_pending)
  );

  assign interrupt_source_reg = {o_fifo_enable, o_fifo_enable,
                                 source_code};

  always_comb begin
    case (addr_q)
      `OFS_INT_SOURCE: read_byte = interrupt_source_reg;
      `OFS_LINE_FORMAT: read_byte = line_format_reg;
      `OFS_INT_MASK: read_byte = interrupt_mask_reg;
      `OFS_FEATURE_CONTROL: read_byte = feature_control_reg;
      `OFS_EXT_FEATURE: read_byte = extended_feature_reg;
      default: read_byte = `REG_RESET;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_hrdata <= 32'h00000000;
    end else if (rd_now) begin
      o_hrdata <= {24'h000000, read_byte};
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_n);

  idle_code_a: assert property (!o_irq_pending |-> source_code == `SRC_NONE
    && interrupt_source_reg[0]) else $error("idle code wrong");
  line_first_a: assert property (active[1] |-> source_code == `SRC_LINE)
    else $error("line status not on top");
  fifo_bits_a: assert property (rd_now && addr_q == `OFS_INT_SOURCE |=>
    o_hrdata[7:6] == {2{$past(o_fifo_enable)}})
    else $error("fifo bits wrong");
  fcr_ignore_a: assert property (wr_sel(bus_state, addr_q,
    `OFS_FIFO_CONTROL) && !wr_data[`FCR_EN] |=> $stable(o_dma_mode)
    && $stable(rx_code) && !o_rx_fifo_clear)
    else $error("control written without enable");
  rx_clear_pulse_a: assert property (wr_sel(bus_state, addr_q,
    `OFS_FIFO_CONTROL) && wr_data[`FCR_EN] && wr_data[`FCR_RX_RST]
    && !$past(o_rx_fifo_clear) |=> o_rx_fifo_clear ##1 !o_rx_fifo_clear)
    else $error("rx clear not one pulse");
  tx_trig_lock_a: assert property (!extended_feature_reg[`EFR_ENH]
    |=> $stable(tx_code)) else $error("tx trigger written");
  timeout_clear_a: assert property (timeout_flag && i_rhr_read
    && !timeout_hit |=> !timeout_flag)
    else $error("timeout not cleared");
  tx_clear_a: assert property (i_thr_write && !tx_event |=> !tx_flag)
    else $error("tx ready not cleared");
  line_set_wins_a: assert property (i_line_error && i_lsr_read
    |=> line_flag) else $error("line event lost");
  pause_gate_a: assert property (!extended_feature_reg[`EFR_ENH]
    |-> source_code != `SRC_PAUSE && source_code != `SRC_FLOW)
    else $error("extended source without enable");
  table_a_a: assert property (feature_control_reg[`FEATURE_CONTROL_REG_TABLE] == 2'b00
    && rx_code == 2'b11 |=> o_rx_trigger == 7'h0E)
    else $error("table A level wrong");

  timeout_cov: cover property (timeout_hit ##1 timeout_flag);
  tx_int_cov: cover property (active[4] ##[1:20] !tx_flag);
  flow_read_cov: cover property (rd_now && source_code == `SRC_FLOW);
endmodule

/* File: uart_far_side.sv */
// Far-side model: the baud generator that feeds the slice's half-bit tick.
// Assumes one clock; the tick stands still while reset is applied.
module uart_far_side (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  output logic o_half_bit_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  // A tick every second cycle keeps character times short in simulation.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_half_bit_tick <= 1'b0;
    end else begin
      o_half_bit_tick <= ~o_half_bit_tick;
    end
  end
endmodule

/* File: uart_line_ctl_tb_top.sv */
// Testbench of the UART control slice: registers, triggers, interrupts.
// Assumes the slice is the only AHB-Lite slave and drives hready itself.
`include "uart_ctl_map.svh"
module uart_line_ctl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hrdy, hresp, tick, modem = 1'b0, rdy_n, rx_rq_n, tx_rq_n;
  logic [7:0] ev = 8'h00;
  logic [6:0] rx_lvl = 7'h00, tx_lvl = 7'h05, rx_trg, tx_trg;
  logic fifo_en, rx_clr, tx_clr, dma, stop_l, par_en, par_ev, irq;
  logic [1:0] wlen;
  logic [7:0] rd_n, q;
  int n_fail = 0, checks_done = 0, n_clr = 0;
  always #5 clk = ~clk;
  // Bus answers are sampled mid-cycle so no edge race decides them.
  always @(negedge clk) begin
    rdy_n <= hrdy;
    rd_n <= hrdata[7:0];
  end
  always @(posedge clk) n_clr <= n_clr + int'(rx_clr) + int'(tx_clr);
  uart_line_ctl DUT (.i_clk_sys(clk), .i_nrst(nrst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp),
    .o_hrdata(hrdata), .i_half_bit_tick(tick), .i_rx_char(1'b0),
    .i_rx_level(rx_lvl), .i_tx_level(tx_lvl), .i_line_error(ev[0]),
    .i_modem_change(modem), .i_pause_match(ev[1]), .i_pause_release(1'b0),
    .i_cts_deassert(ev[2]), .i_rts_deassert(ev[7]), .i_rhr_read(ev[3]),
    .i_thr_write(ev[6]), .i_lsr_read(ev[4]), .i_msr_read(ev[5]),
    .o_fifo_enable(fifo_en), .o_rx_fifo_clear(rx_clr),
    .o_tx_fifo_clear(tx_clr), .o_dma_mode(dma), .o_rx_trigger(rx_trg),
    .o_tx_trigger(tx_trg), .o_word_length(wlen), .o_stop_long(stop_l),
    .o_parity_enable(par_en), .o_parity_even(par_ev),
    .o_rx_request_pin_n(rx_rq_n), .o_tx_request_pin_n(tx_rq_n),
    .o_irq_pending(irq));
  uart_far_side far (.i_clk_sys(clk), .i_nrst(nrst), .o_half_bit_tick(tick));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (!rdy_n) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge clk);
    while (!rdy_n) @(posedge clk);
    q = rd_n;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Each bit of the mask raises one event input for a single cycle.
  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
  endtask
  task automatic t_reset;
    rd(`OFS_INT_SOURCE, 8'h01);
    rd(`OFS_LINE_FORMAT, 8'h00);
    chk({1'b0, rx_trg}, 8'h01);
    chk({1'b0, tx_trg}, 8'h01);
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_fifo;
    wr(`OFS_FIFO_CONTROL, 8'h0E);
    wt(2);
    chk({fifo_en, dma, n_clr[5:0]}, 8'h00);
    wr(`OFS_FIFO_CONTROL, 8'h0F);
    wt(3);
    chk({fifo_en, dma, n_clr[5:0]}, 8'hC2);
    rd(`OFS_INT_SOURCE, 8'hC1);
    wr(`OFS_FIFO_CONTROL, 8'h00);
    wt(2);
    chk({7'h0, dma}, 8'h01);
    rd(`OFS_INT_SOURCE, 8'h01);
    rd(`OFS_FIFO_CONTROL, 8'h00);
    wr(`OFS_FIFO_CONTROL, 8'h01);
    wt(2);
    chk({6'h0, fifo_en, dma}, 8'h02);
    $display("test fifo done");
  endtask
  task automatic t_tables;
    logic [6:0] erx [12];
    logic [6:0] etx [12];
    erx = '{7'h01, 7'h04, 7'h08, 7'h0E, 7'h08, 7'h10, 7'h18, 7'h1C,
            7'h08, 7'h10, 7'h38, 7'h3C};
    etx = '{7'h01, 7'h01, 7'h01, 7'h01, 7'h10, 7'h08, 7'h18, 7'h1E,
            7'h08, 7'h10, 7'h20, 7'h38};
    wr(`OFS_EXT_FEATURE, 8'h10);
    for (int t = 0; t < 3; t++) begin
      wr(`OFS_FEATURE_CONTROL, {2'h0, 2'(t), 4'h0});
      for (int c = 0; c < 4; c++) begin
        wr(`OFS_FIFO_CONTROL, {2'(c), 2'(c), 4'h1});
        wt(2);
        chk({1'b0, rx_trg}, {1'b0, erx[t * 4 + c]});
        chk({1'b0, tx_trg}, {1'b0, etx[t * 4 + c]});
      end
    end
    wr(`OFS_FEATURE_CONTROL, 8'h10);
    wr(`OFS_FIFO_CONTROL, 8'h01);
    wr(`OFS_EXT_FEATURE, 8'h00);
    wr(`OFS_FIFO_CONTROL, 8'h31);
    wt(2);
    chk({1'b0, tx_trg}, 8'h10);
    wr(`OFS_EXT_FEATURE, 8'h10);
    wr(`OFS_FEATURE_CONTROL, 8'h30);
    wr(`OFS_PROG_TRIGGER, 8'h05);
    wr(`OFS_FEATURE_CONTROL, 8'hB0);
    wr(`OFS_PROG_TRIGGER, 8'h09);
    wt(2);
    chk({rx_trg[3:0], tx_trg[3:0]}, 8'h59);
    wr(`OFS_FEATURE_CONTROL, 8'h00);
    wr(`OFS_FIFO_CONTROL, 8'hC1);
    $display("test tables done");
  endtask
  task automatic t_format;
    for (int i = 0; i < 32; i++) begin
      wr(`OFS_LINE_FORMAT, 8'(i));
      wt(1);
      rd(`OFS_LINE_FORMAT, 8'(i));
      chk({3'h0, par_ev, par_en, stop_l, wlen}, 8'(i));
    end
    wr(`OFS_LINE_FORMAT, 8'h00);
    $display("test format done");
  endtask
  task automatic t_irq;
    @(posedge clk);
    tx_lvl <= 7'h00;
    wr(`OFS_INT_MASK, 8'hEE);
    @(posedge clk);
    tx_lvl <= 7'h05;
    pulse(8'h04);
    pulse(8'h02);
    pulse(8'h01);
    @(posedge clk);
    modem <= 1'b1;
    wt(2);
    chk({7'h0, irq}, 8'h01);
    rd(`OFS_INT_SOURCE, 8'hC6);
    // A new line error in the cycle of a status read must survive it.
    pulse(8'h11);
    rd(`OFS_INT_SOURCE, 8'hC6);
    pulse(8'h10);
    rd(`OFS_INT_SOURCE, 8'hC2);
    rd(`OFS_INT_SOURCE, 8'hC0);
    modem <= 1'b0;
    rd(`OFS_INT_SOURCE, 8'hD0);
    rd(`OFS_INT_SOURCE, 8'hE0);
    pulse(8'h20);
    rd(`OFS_INT_SOURCE, 8'hC1);
    wr(`OFS_INT_MASK, 8'hCE);
    pulse(8'h02);
    rd(`OFS_INT_SOURCE, 8'hC1);
    wr(`OFS_INT_MASK, 8'hEE);
    rd(`OFS_INT_SOURCE, 8'hD0);
    wr(`OFS_INT_MASK, 8'h2E);
    pulse(8'h80);
    rd(`OFS_INT_SOURCE, 8'hC1);
    wr(`OFS_INT_MASK, 8'h6E);
    rd(`OFS_INT_SOURCE, 8'hE0);
    pulse(8'h20);
    @(posedge clk);
    tx_lvl <= 7'h00;
    wt(2);
    chk({7'h0, irq}, 8'h01);
    pulse(8'h40);
    rd(`OFS_INT_SOURCE, 8'hC1);
    tx_lvl <= 7'h05;
    $display("test interrupts done");
  endtask
  task automatic t_timeout;
    int n;
    wr(`OFS_INT_MASK, 8'h01);
    @(posedge clk);
    rx_lvl <= 7'h01;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      wt(1);
      n++;
    end
    // A 5-bit frame is 14 half bits: 80 ticks, a tick every second cycle.
    chk({7'h0, n >= 155 && n <= 170}, 8'h01);
    chk({5'h0, hresp, rx_rq_n, tx_rq_n}, 8'h01);
    rd(`OFS_INT_SOURCE, 8'hCC);
    rx_lvl <= 7'h0E;
    rd(`OFS_INT_SOURCE, 8'hCC);
    pulse(8'h08);
    rd(`OFS_INT_SOURCE, 8'hC4);
    rx_lvl <= 7'h00;
    rd(`OFS_INT_SOURCE, 8'hC1);
    // In DMA mode one character, far below the trigger of 14, keeps the pin idle.
    wr(`OFS_FIFO_CONTROL, 8'hC9);
    rx_lvl <= 7'h01;
    wt(2);
    chk({6'h0, rx_rq_n, tx_rq_n}, 8'h03);
    $display("test timeout done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_fifo();
    t_tables();
    t_format();
    t_irq();
    t_timeout();
    summarize();
  end
  initial begin
    #200000;
    n_fail++;
    summarize();
  end
endmodule
